/* File: tb/scc_link_monitor.sv */
// concurrent checks on the command link between host and device
`timescale 1ns/10ps
`default_nettype none
`include "scc_map.svh"
module scc_link_monitor (
    input wire logic clk,
    input wire logic rst,
    input wire logic cmd_valid,
    input wire logic cmd_ready,
    input wire logic [7:0] cmd_addr,
    input wire logic [55:0] cmd_data,
    input wire logic spi_sel,
    input wire logic rsp_valid,
    input wire logic [7:0] rsp_byte
);
    // ----------------
    // link properties
    // ----------------
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    logic take;
    logic ans;
    logic qspi;
    logic plain;
    logic [3:0] run_reg;
    logic [3:0] run_next;
    assign take = cmd_valid && cmd_ready;
    // a plain query and any buffer fetch send bytes back; ans covers the fetch only with spi_sel
    assign ans = take && ((cmd_addr == `SCC_OFF_QUERY && !spi_sel)
        || (cmd_addr == `SCC_OFF_OUT_BUF && spi_sel));
    assign qspi = take && cmd_addr == `SCC_OFF_QUERY && spi_sel;
    assign plain = take && cmd_addr != `SCC_OFF_QUERY
        && cmd_addr != `SCC_OFF_OUT_BUF;
    always_comb begin
        run_next = rsp_valid ? run_reg + 4'h1 : 4'h0;
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            run_reg <= 4'h0;
        end else begin
            run_reg <= run_next;
        end
    end
    a_answer_eight_bytes: assert property (ans |=> !rsp_valid ##1
        rsp_valid [*8] ##1 !rsp_valid) else $error("answer not 8 bytes");
    // the fetch that follows can answer from the fourth cycle on
    a_spi_query_quiet: assert property (qspi |=> !rsp_valid [*3])
        else $error("spi query sent bytes");
    a_plain_cmd_quiet: assert property (plain |=> !rsp_valid [*8])
        else $error("command without answer sent bytes");
    a_ready_while_send: assert property (ans |=> !cmd_ready [*7]
        ##[1:2] cmd_ready) else $error("ready wrong around send");
    a_ready_return: assert property (take && !ans |=> !cmd_ready
        ##1 cmd_ready) else $error("ready not back after command");
    a_cmd_holds: assert property (cmd_valid && !cmd_ready |=>
        cmd_valid && $stable(cmd_addr) && $stable(cmd_data))
        else $error("command changed before taken");
    a_rsp_has_cause: assert property ($rose(rsp_valid) |->
        $past(ans, 2)) else $error("bytes without a query");
    a_burst_bounded: assert property (run_reg <= 4'h8)
        else $error("burst longer than 8 bytes");
endmodule
`default_nettype wire

/* File: tb/tb_synth_config_command_regs.sv */
// self-checking bench: host controller and device joined by the link
`timescale 1ns/10ps
`default_nettype none
`include "scc_map.svh"
module tb_synth_config_command_regs;
    logic clk, rst, hsel, hwrite, hreadyout, hresp, nvm_load_req;
    logic [31:0] haddr, hwdata, hrdata, cur_phase, dwell_time, sweep_cycles;
    logic [1:0] htrans;
    logic nvm_load_valid, nvm_save, cal_start, cal_sum, freq_update;
    logic list_trigger, sweep_mode, low_loop_gain, intn_lock, fine_res;
    logic spur_active, list_running;
    logic [60:0] nvm_load_data, nvm_save_data, saved;
    logic [55:0] fixed_tone_freq_reg, freq_x;
    logic [20:0] uart_rate;
    logic [5:0] pll_status;
    logic [63:0] sweep_start, sweep_stop, sweep_step;
    logic [4:0] mode_x;
    int err_total, cmp_count, save_cnt, cal_cnt, freq_cnt, trig_cnt;
    scc_if scc_if_inst();
    scc_dev scc_dev_inst (.clk(clk), .rst(rst), .lnk(scc_if_inst.dev),
        .nvm_load_req(nvm_load_req), .nvm_load_valid(nvm_load_valid),
        .nvm_load_data(nvm_load_data), .nvm_save(nvm_save),
        .nvm_save_data(nvm_save_data), .cal_start(cal_start),
        .cal_sum(cal_sum), .freq_update(freq_update),
        .fixed_tone_freq_reg(fixed_tone_freq_reg),
        .list_trigger(list_trigger), .sweep_mode(sweep_mode),
        .low_loop_gain(low_loop_gain), .intn_lock(intn_lock),
        .fine_res(fine_res), .spur_active(spur_active),
        .uart_rate(uart_rate), .pll_status(pll_status),
        .list_running(list_running), .cur_phase(cur_phase),
        .sweep_start(sweep_start), .sweep_stop(sweep_stop),
        .sweep_step(sweep_step), .dwell_time(dwell_time),
        .sweep_cycles(sweep_cycles));
    scc_host scc_host_inst (.clk(clk), .rst(rst), .lnk(scc_if_inst.host),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata));
    scc_link_monitor scc_link_monitor_inst (.clk(clk), .rst(rst),
        .cmd_valid(scc_if_inst.cmd_valid), .cmd_ready(scc_if_inst.cmd_ready),
        .cmd_addr(scc_if_inst.cmd_addr), .cmd_data(scc_if_inst.cmd_data),
        .spi_sel(scc_if_inst.spi_sel), .rsp_valid(scc_if_inst.rsp_valid),
        .rsp_byte(scc_if_inst.rsp_byte));
    // ----------------
    // helpers
    // ----------------
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // the memory answers each load request with a single pulse
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            nvm_load_valid <= 1'b0;
        end else begin
            nvm_load_valid <= nvm_load_req && !nvm_load_valid;
        end
    end
    always @(posedge clk) begin
        if (nvm_save === 1'b1) begin
            save_cnt++;
            saved = nvm_save_data;
        end
        if (cal_start === 1'b1) cal_cnt++;
        if (freq_update === 1'b1) freq_cnt++;
        if (list_trigger === 1'b1) trig_cnt++;
    end
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic ahb(input logic w, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] r);
        int n;
        n = 0;
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        hwrite <= w;
        htrans <= 2'h2;
        do begin @(posedge clk); n++; end while (hreadyout !== 1'b1 && n < 20);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do begin @(posedge clk); n++; end while (hreadyout !== 1'b1 && n < 40);
        r = hrdata;
        if (n >= 20) begin
            err_total++;
            summarize();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        ahb(1'b1, a, d, x);
    endtask
    // polling starts two edges late so a stale done bit is never seen
    task automatic cmd(input logic [7:0] a, input logic [55:0] d,
        input logic spi);
        logic [31:0] s;
        int n;
        wr(`SCC_H_ADDR, {24'h0, a});
        wr(`SCC_H_DATA_LO, d[31:0]);
        wr(`SCC_H_DATA_HI, {8'h0, d[55:32]});
        wr(`SCC_H_CTRL, {30'h0, spi, 1'b1});
        repeat (2) @(posedge clk);
        n = 0;
        s = 32'h1;
        while (s[1:0] !== 2'h2 && n < 50) begin
            ahb(1'b0, `SCC_H_STATUS, 32'h0, s);
            n++;
        end
        if (n >= 50) begin
            err_total++;
            summarize();
        end
    endtask
    task automatic result(input logic [63:0] e);
        logic [31:0] lo, hi;
        ahb(1'b0, `SCC_H_RES_LO, 32'h0, lo);
        ahb(1'b0, `SCC_H_RES_HI, 32'h0, hi);
        chk({hi, lo}, e);
    endtask
    task automatic set_mode(input logic [4:0] m);
        cmd(`SCC_OFF_MODE, {51'h0, m}, 1'b0);
        mode_x = m;
    endtask
    // ----------------
    // scenarios
    // ----------------
    task automatic t_reset_load();
        int n;
        n = 0;
        while (scc_if_inst.cmd_ready !== 1'b1 && n < 20) begin
            @(posedge clk);
            n++;
        end
        if (n >= 20) begin
            err_total++;
            summarize();
        end
        chk(fixed_tone_freq_reg, 64'h12_3456);
        chk(uart_rate, 64'he100);
        chk({fine_res, sweep_mode}, 64'h0);
    endtask
    task automatic t_save();
        cmd(`SCC_OFF_SAVE, 56'h1, 1'b0);
        chk(save_cnt, 64'h0);
        cmd(`SCC_OFF_SAVE, 56'h0, 1'b0);
        chk(save_cnt, 64'h1);
        chk(saved, {mode_x, freq_x});
    endtask
    task automatic t_cal();
        for (int b = 0; b < 2; b++) begin
            cmd(`SCC_OFF_SELF_CAL, 56'(b), 1'b0);
            chk({cal_cnt[7:0], 7'h0, cal_sum}, {8'(b + 1), 8'(b)});
        end
    endtask
    task automatic t_mode();
        logic [4:0] m;
        for (int v = 0; v < 32; v++) begin
            m = 5'(v);
            set_mode(m);
            chk({spur_active, fine_res, intn_lock, low_loop_gain,
                sweep_mode}, {m[4] & ~m[2], m[3:0]});
        end
    endtask
    task automatic t_fixed();
        set_mode(5'h0);
        cmd(`SCC_OFF_FIXED_FREQ, 56'hab_cdef_0123, 1'b0);
        freq_x = 56'hab_cdef_0123;
        chk({freq_cnt[7:0], fixed_tone_freq_reg}, {8'h1, freq_x});
        cmd(`SCC_OFF_SOFT_TRIG, 56'h0, 1'b0);
        chk(trig_cnt, 64'h0);
        set_mode(5'h1);
        cmd(`SCC_OFF_FIXED_FREQ, 56'h77, 1'b0);
        chk({freq_cnt[7:0], fixed_tone_freq_reg}, {8'h1, freq_x});
        cmd(`SCC_OFF_SOFT_TRIG, 56'h0, 1'b0);
        chk(trig_cnt, 64'h1);
    endtask
    task automatic t_baud();
        logic [20:0] rate [0:7] = '{21'he100, 21'h1c200, 21'h4b00,
            21'h9600, 21'h38400, 21'h70800, 21'he1000, 21'h1c2000};
        for (int i = 0; i < 10; i++) begin
            cmd(`SCC_OFF_UART_RATE, 56'(i < 8 ? i : i + 6), 1'b0);
            chk(uart_rate, rate[i < 8 ? i : 7]);
        end
    endtask
    task automatic t_query();
        logic [63:0] e [0:7];
        e = '{{50'h0, list_running, mode_x, 2'h0, pll_status},
            {8'h0, freq_x}, {32'h0, cur_phase}, sweep_start, sweep_stop,
            sweep_step, {32'h0, dwell_time}, {32'h0, sweep_cycles}};
        for (int c = 0; c < 8; c++) begin
            cmd(`SCC_OFF_QUERY, 56'(c), 1'b0);
            result(e[c]);
        end
        cmd(`SCC_OFF_QUERY, 56'h9, 1'b0);
        result(64'h0);
        // the host fetches the buffer on its own after a spi query
        cmd(`SCC_OFF_QUERY, 56'h4, 1'b1);
        result(sweep_stop);
        cmd(`SCC_OFF_OUT_BUF, 56'h0, 1'b1);
        result(64'h0);
    endtask
    initial begin
        err_total = 0;
        cmp_count = 0;
        {save_cnt, cal_cnt, freq_cnt, trig_cnt} = '0;
        {hsel, hwrite, haddr, hwdata, htrans} = '0;
        nvm_load_data = {5'h0, 56'h12_3456};
        freq_x = 56'h12_3456;
        mode_x = 5'h0;
        pll_status = 6'h2d;
        list_running = 1'b1;
        cur_phase = 32'h0000_010e;
        sweep_start = 64'h0000_0001_2345_6789;
        sweep_stop = 64'h0000_0002_468a_cf13;
        sweep_step = 64'h0000_0000_0001_86a0;
        dwell_time = 32'h0000_0014;
        sweep_cycles = 32'h0000_0003;
        rst = 1'b1;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_reset_load();
        t_save();
        t_cal();
        t_mode();
        t_fixed();
        t_baud();
        t_query();
        summarize();
    end
endmodule
`default_nettype wire

/* File: verilog/scc_dev.sv */
// synthesizer command registers: device end of the command link
//
// Local design decision: the AHB-Lite slave port.
`timescale 1ns/10ps
`default_nettype none
`include "scc_map.svh"
module scc_dev (
    input wire logic clk,
    input wire logic rst,
    scc_if.dev lnk,
    output logic nvm_load_req,
    input wire logic nvm_load_valid,
    input wire logic [60:0] nvm_load_data,
    output logic nvm_save,
    output logic [60:0] nvm_save_data,
    output logic cal_start,
    output logic cal_sum,
    output logic freq_update,
    output logic [55:0] fixed_tone_freq_reg,
    output logic list_trigger,
    output logic sweep_mode,
    output logic low_loop_gain,
    output logic intn_lock,
    output logic fine_res,
    output logic spur_active,
    output logic [20:0] uart_rate,
    input wire logic [5:0] pll_status,
    input wire logic list_running,
    input wire logic [31:0] cur_phase,
    input wire logic [63:0] sweep_start,
    input wire logic [63:0] sweep_stop,
    input wire logic [63:0] sweep_step,
    input wire logic [31:0] dwell_time,
    input wire logic [31:0] sweep_cycles
);
    // ------------------------------------------------------------
    // decoding helpers
    // ------------------------------------------------------------
    function automatic logic [20:0] baud_of(input logic [3:0] idx);
        case (idx)
            4'h0: baud_of = 21'd57600;
            4'h1: baud_of = 21'd115200;
            4'h2: baud_of = 21'd19200;
            4'h3: baud_of = 21'd38400;
            4'h4: baud_of = 21'd230400;
            4'h5: baud_of = 21'd460800;
            4'h6: baud_of = 21'd921600;
            default: baud_of = 21'd1843200;
        endcase
    endfunction

    logic [4:0] mode_reg, mode_next;
    logic [55:0] freq_reg, freq_next;
    logic [3:0] baud_reg, baud_next;

    function automatic logic [63:0] query_of(input logic [3:0] code);
        query_of = 64'h0;
        case (code)
            4'h0: begin
                query_of[5:0] = pll_status;
                query_of[`SCC_STAT_MODE_LSB +: 5] = mode_reg;
                query_of[`SCC_STAT_RUN] = list_running;
            end
            4'h1: query_of = {8'h00, freq_reg};
            4'h2: query_of = {32'h0, cur_phase};
            4'h3: query_of = sweep_start;
            4'h4: query_of = sweep_stop;
            4'h5: query_of = sweep_step;
            4'h6: query_of = {32'h0, dwell_time};
            4'h7: query_of = {32'h0, sweep_cycles};
            default: query_of = 64'h0;
        endcase
    endfunction

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    scc_pkg::scc_dev_state_t st_reg, st_next;
    logic [63:0] buf_reg, buf_next;
    logic [3:0] cnt_reg, cnt_next;
    logic ready_reg, ready_next;
    logic rsp_valid_reg, rsp_valid_next;
    logic [7:0] rsp_byte_reg, rsp_byte_next;
    logic load_req_reg, load_req_next;
    logic save_reg, save_next;
    logic cal_reg, cal_next;
    logic cal_sum_reg, cal_sum_next;
    logic upd_reg, upd_next;
    logic trig_reg, trig_next;
    logic spur_reg, spur_next;
    logic [20:0] rate_reg, rate_next;
    logic take;

    assign take = lnk.cmd_valid && ready_reg;

    always_comb begin
        st_next = st_reg;
        buf_next = buf_reg;
        cnt_next = cnt_reg;
        mode_next = mode_reg;
        freq_next = freq_reg;
        baud_next = baud_reg;
        load_req_next = 1'b0;
        save_next = 1'b0;
        cal_next = 1'b0;
        cal_sum_next = cal_sum_reg;
        upd_next = 1'b0;
        trig_next = 1'b0;
        rsp_valid_next = 1'b0;
        rsp_byte_next = rsp_byte_reg;
        case (st_reg)
            scc_pkg::SCC_LOAD: begin
                load_req_next = 1'b1;
                if (nvm_load_valid) begin
                    // defaults come back before any command is taken
                    freq_next = nvm_load_data[55:0];
                    mode_next = nvm_load_data[60:56];
                    load_req_next = 1'b0;
                    st_next = scc_pkg::SCC_IDLE;
                end
            end
            scc_pkg::SCC_IDLE: begin
                if (take) begin
                    case (lnk.cmd_addr)
                        `SCC_OFF_SAVE: begin
                            save_next = (lnk.cmd_data == 56'h0);
                        end
                        `SCC_OFF_SELF_CAL: begin
                            cal_next = 1'b1;
                            cal_sum_next = lnk.cmd_data[0];
                        end
                        `SCC_OFF_MODE: begin
                            mode_next = lnk.cmd_data[4:0];
                        end
                        `SCC_OFF_FIXED_FREQ: begin
                            if (!mode_reg[`SCC_MODE_SWEEP]) begin
                                freq_next = lnk.cmd_data;
                                upd_next = 1'b1;
                            end
                        end
                        `SCC_OFF_SOFT_TRIG: begin
                            trig_next = mode_reg[`SCC_MODE_SWEEP];
                        end
                        `SCC_OFF_UART_RATE: begin
                            if (lnk.cmd_data[3:0] <= `SCC_BAUD_MAX) begin
                                baud_next = lnk.cmd_data[3:0];
                            end
                        end
                        `SCC_OFF_QUERY: begin
                            buf_next = query_of(lnk.cmd_data[3:0]);
                            if (!lnk.spi_sel) begin
                                cnt_next = `SCC_RESULT_BYTES;
                                st_next = scc_pkg::SCC_SEND;
                            end
                        end
                        `SCC_OFF_OUT_BUF: begin
                            cnt_next = `SCC_RESULT_BYTES;
                            st_next = scc_pkg::SCC_SEND;
                        end
                        default: begin
                        end
                    endcase
                end
            end
            scc_pkg::SCC_SEND: begin
                // low byte first; shifting in zeros clears the buffer
                rsp_valid_next = 1'b1;
                rsp_byte_next = buf_reg[7:0];
                buf_next = {8'h00, buf_reg[63:8]};
                cnt_next = cnt_reg - 4'h1;
                if (cnt_reg == 4'h1) begin
                    st_next = scc_pkg::SCC_IDLE;
                end
            end
            default: begin
                st_next = scc_pkg::SCC_LOAD;
            end
        endcase
        ready_next = (st_next == scc_pkg::SCC_IDLE) && !take;
        // spur suppression only acts while integer-N lock (intn_lock) is off
        spur_next = mode_next[`SCC_MODE_SPUR] &&
            !mode_next[`SCC_MODE_INTN];
        rate_next = baud_of(baud_next);
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_reg <= scc_pkg::SCC_LOAD;
            buf_reg <= 64'h0;
            cnt_reg <= 4'h0;
            mode_reg <= `SCC_MODE_RST;
            freq_reg <= `SCC_FREQ_RST;
            baud_reg <= `SCC_BAUD_RST;
            ready_reg <= 1'b0;
            rsp_valid_reg <= 1'b0;
            rsp_byte_reg <= 8'h00;
            load_req_reg <= 1'b0;
            save_reg <= 1'b0;
            cal_reg <= 1'b0;
            cal_sum_reg <= 1'b0;
            upd_reg <= 1'b0;
            trig_reg <= 1'b0;
            spur_reg <= 1'b0;
            rate_reg <= `SCC_RATE_RST;
        end else begin
            st_reg <= st_next;
            buf_reg <= buf_next;
            cnt_reg <= cnt_next;
            mode_reg <= mode_next;
            freq_reg <= freq_next;
            baud_reg <= baud_next;
            ready_reg <= ready_next;
            rsp_valid_reg <= rsp_valid_next;
            rsp_byte_reg <= rsp_byte_next;
            load_req_reg <= load_req_next;
            save_reg <= save_next;
            cal_reg <= cal_next;
            cal_sum_reg <= cal_sum_next;
            upd_reg <= upd_next;
            trig_reg <= trig_next;
            spur_reg <= spur_next;
            rate_reg <= rate_next;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign lnk.cmd_ready = ready_reg;
    assign lnk.rsp_valid = rsp_valid_reg;
    assign lnk.rsp_byte = rsp_byte_reg;
    assign nvm_load_req = load_req_reg;
    assign nvm_save = save_reg;
    assign nvm_save_data = {mode_reg, freq_reg};
    assign cal_start = cal_reg;
    assign cal_sum = cal_sum_reg;
    assign freq_update = upd_reg;
    assign fixed_tone_freq_reg = freq_reg;
    assign list_trigger = trig_reg;
    assign sweep_mode = mode_reg[`SCC_MODE_SWEEP];
    assign low_loop_gain = mode_reg[`SCC_MODE_LOW_GAIN];
    assign intn_lock = mode_reg[`SCC_MODE_INTN];
    assign fine_res = mode_reg[`SCC_MODE_FINE_RES];
    assign spur_active = spur_reg;
    assign uart_rate = rate_reg;
endmodule
`default_nettype wire

/* File: verilog/scc_host.sv */
// host controller end of the command link, driven over ahb-lite
`timescale 1ns/10ps
`default_nettype none
`include "scc_map.svh"
module scc_host (
    input wire logic clk,
    input wire logic rst,
    scc_if.host lnk,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata
);
    // ------------------------------------------------------------
    // bus slave and command sequencer
    // ------------------------------------------------------------
    scc_pkg::scc_host_state_t st_reg, st_next;
    logic wr_pend_reg, wr_pend_next;
    logic [7:0] wa_reg, wa_next;
    logic [31:0] rdata_reg, rdata_next;
    logic [7:0] addr_reg, addr_next;
    logic [55:0] data_reg, data_next;
    logic spi_reg, spi_next;
    logic done_reg, done_next;
    logic [63:0] res_reg, res_next;
    logic [3:0] cnt_reg, cnt_next;
    logic cv_reg, cv_next;
    logic [7:0] ca_reg, ca_next;
    logic [55:0] cd_reg, cd_next;
    logic aphase;
    logic busy;

    assign aphase = hsel && hready && htrans[1];
    assign busy = (st_reg != scc_pkg::SCC_H_IDLE);

    always_comb begin
        st_next = st_reg;
        wr_pend_next = aphase && hwrite;
        wa_next = aphase ? haddr[7:0] : wa_reg;
        rdata_next = rdata_reg;
        addr_next = addr_reg;
        data_next = data_reg;
        spi_next = spi_reg;
        done_next = done_reg;
        res_next = res_reg;
        cnt_next = cnt_reg;
        cv_next = cv_reg;
        ca_next = ca_reg;
        cd_next = cd_reg;
        if (aphase && !hwrite) begin
            case (haddr[7:0])
                `SCC_H_ADDR: rdata_next = {24'h0, addr_reg};
                `SCC_H_DATA_LO: rdata_next = data_reg[31:0];
                `SCC_H_DATA_HI: rdata_next = {8'h00, data_reg[55:32]};
                `SCC_H_CTRL: rdata_next = {30'h0, spi_reg, 1'b0};
                `SCC_H_STATUS: rdata_next = {30'h0, done_reg, busy};
                `SCC_H_RES_LO: rdata_next = res_reg[31:0];
                `SCC_H_RES_HI: rdata_next = res_reg[63:32];
                default: rdata_next = 32'h0;
            endcase
        end
        if (wr_pend_reg) begin
            case (wa_reg)
                `SCC_H_ADDR: addr_next = hwdata[7:0];
                `SCC_H_DATA_LO: data_next[31:0] = hwdata;
                `SCC_H_DATA_HI: data_next[55:32] = hwdata[23:0];
                `SCC_H_CTRL: begin
                    spi_next = hwdata[`SCC_CTRL_SPI];
                    // a start while busy is dropped
                    if (hwdata[`SCC_CTRL_GO] && !busy) begin
                        done_next = 1'b0;
                        cv_next = 1'b1;
                        ca_next = addr_reg;
                        cd_next = data_reg;
                        st_next = scc_pkg::SCC_H_CMD;
                    end
                end
                default: begin
                end
            endcase
        end
        case (st_reg)
            scc_pkg::SCC_H_CMD: begin
                if (lnk.cmd_ready) begin
                    cv_next = 1'b0;
                    cnt_next = `SCC_RESULT_BYTES;
                    if (ca_reg == `SCC_OFF_QUERY && spi_reg) begin
                        st_next = scc_pkg::SCC_H_FETCH;
                    end else if (ca_reg == `SCC_OFF_QUERY ||
                        ca_reg == `SCC_OFF_OUT_BUF) begin
                        st_next = scc_pkg::SCC_H_RECV;
                    end else begin
                        done_next = 1'b1;
                        st_next = scc_pkg::SCC_H_IDLE;
                    end
                end
            end
            scc_pkg::SCC_H_FETCH: begin
                // second access shifts the buffered result out
                cv_next = 1'b1;
                ca_next = `SCC_OFF_OUT_BUF;
                cd_next = 56'h0;
                st_next = scc_pkg::SCC_H_CMD;
            end
            scc_pkg::SCC_H_RECV: begin
                if (lnk.rsp_valid) begin
                    res_next = {lnk.rsp_byte, res_reg[63:8]};
                    cnt_next = cnt_reg - 4'h1;
                    if (cnt_reg == 4'h1) begin
                        done_next = 1'b1;
                        st_next = scc_pkg::SCC_H_IDLE;
                    end
                end
            end
            default: begin
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_reg <= scc_pkg::SCC_H_IDLE;
            wr_pend_reg <= 1'b0;
            wa_reg <= 8'h00;
            rdata_reg <= 32'h0;
            addr_reg <= 8'h00;
            data_reg <= 56'h0;
            spi_reg <= 1'b0;
            done_reg <= 1'b0;
            res_reg <= 64'h0;
            cnt_reg <= 4'h0;
            cv_reg <= 1'b0;
            ca_reg <= 8'h00;
            cd_reg <= 56'h0;
        end else begin
            st_reg <= st_next;
            wr_pend_reg <= wr_pend_next;
            wa_reg <= wa_next;
            rdata_reg <= rdata_next;
            addr_reg <= addr_next;
            data_reg <= data_next;
            spi_reg <= spi_next;
            done_reg <= done_next;
            res_reg <= res_next;
            cnt_reg <= cnt_next;
            cv_reg <= cv_next;
            ca_reg <= ca_next;
            cd_reg <= cd_next;
        end
    end

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = rdata_reg;
    assign lnk.cmd_valid = cv_reg;
    assign lnk.cmd_addr = ca_reg;
    assign lnk.cmd_data = cd_reg;
    assign lnk.spi_sel = spi_reg;
endmodule
`default_nettype wire

/* File: verilog/scc_if.sv */
// command link between host controller and synthesizer command block
`timescale 1ns/10ps
`default_nettype none
interface scc_if;
    logic cmd_valid;
    logic cmd_ready;
    logic [7:0] cmd_addr;
    logic [55:0] cmd_data;
    logic spi_sel;
    logic rsp_valid;
    logic [7:0] rsp_byte;
    modport dev (input cmd_valid, cmd_addr, cmd_data, spi_sel,
        output cmd_ready, rsp_valid, rsp_byte);
    modport host (output cmd_valid, cmd_addr, cmd_data, spi_sel,
        input cmd_ready, rsp_valid, rsp_byte);
endinterface
`default_nettype wire

/* File: verilog/scc_map.svh */
// register offsets, field positions, reset values and counts
`ifndef SCC_MAP_SVH
`define SCC_MAP_SVH
// device command offsets on the link
`define SCC_OFF_SOFT_TRIG 8'h0f
`define SCC_OFF_FIXED_FREQ 8'h10
`define SCC_OFF_SAVE 8'h12
`define SCC_OFF_SELF_CAL 8'h13
`define SCC_OFF_MODE 8'h14
`define SCC_OFF_UART_RATE 8'h15
`define SCC_OFF_QUERY 8'h20
`define SCC_OFF_OUT_BUF 8'h25
// synthesis mode fields
`define SCC_MODE_SWEEP 0
`define SCC_MODE_LOW_GAIN 1
`define SCC_MODE_INTN 2
`define SCC_MODE_FINE_RES 3
`define SCC_MODE_SPUR 4
`define SCC_MODE_RST 5'h00
`define SCC_FREQ_RST 56'h0
`define SCC_BAUD_RST 4'h0
`define SCC_BAUD_MAX 4'h7
`define SCC_RATE_RST 21'h0e100
// status word field positions
`define SCC_STAT_MODE_LSB 8
`define SCC_STAT_RUN 13
`define SCC_RESULT_BYTES 4'h8
// host controller registers on the ahb-lite bus
`define SCC_H_ADDR 8'h00
`define SCC_H_DATA_LO 8'h04
`define SCC_H_DATA_HI 8'h08
`define SCC_H_CTRL 8'h0c
`define SCC_H_STATUS 8'h10
`define SCC_H_RES_LO 8'h14
`define SCC_H_RES_HI 8'h18
`define SCC_CTRL_GO 0
`define SCC_CTRL_SPI 1
`endif

/* File: verilog/scc_pkg.sv */
// types shared by both ends of the command link
package scc_pkg;
    typedef enum logic [2:0] {
        SCC_LOAD = 3'b001,
        SCC_IDLE = 3'b010,
        SCC_SEND = 3'b100
    } scc_dev_state_t;
    typedef enum logic [3:0] {
        SCC_H_IDLE = 4'b0001,
        SCC_H_CMD = 4'b0010,
        SCC_H_FETCH = 4'b0100,
        SCC_H_RECV = 4'b1000
    } scc_host_state_t;
endpackage
